// file: hw/ppm_pkg.sv
/*
 * package of the parallel port master: field codes, reset values and
 * per-mode cycle counts.
 * assumes one clock, the peripheral bus clock, at 100 MHz.
 */
package ppm_pkg;
    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_MASTER2 = 2'h2;
    localparam logic [1:0] MUX_DEMUX = 2'h0;
    localparam logic [1:0] MUX_PARTIAL = 2'h1;
    localparam logic [1:0] MUX_FULL8 = 2'h2;
    localparam logic [1:0] MUX_FULL16 = 2'h3;
    localparam logic [1:0] INC_UP = 2'h1;
    localparam logic [1:0] INC_DOWN = 2'h2;
    localparam logic [1:0] IRQ_EVERY = 2'h1;
    localparam logic [1:0] CSF_A15_A14 = 2'h0;
    localparam logic [1:0] CSF_HI_ONLY = 2'h1;
    localparam logic [1:0] CSF_BOTH = 2'h2;
    // ------------------------------------------------------------
    // address bit positions
    // ------------------------------------------------------------
    localparam int SEL_HI_BIT = 15;
    localparam int SEL_LO_BIT = 14;
    localparam int ALL_PIN = 0;
    localparam int ALH_PIN = 1;
    // ------------------------------------------------------------
    // cycles of the address phase per multiplex mode, data phase
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CYC_DEMUX = 4'h0;
    localparam logic [3:0] ADDR_CYC_PARTIAL = 4'h3;
    localparam logic [3:0] ADDR_CYC_FULL8 = 4'h6;
    localparam logic [3:0] ADDR_CYC_FULL16 = 4'h3;
    localparam logic [3:0] DATA_CYC_READ = 4'h2;
    localparam logic [3:0] DATA_CYC_WRITE = 4'h3;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [15:0] RST_DATA = 16'h0000;
endpackage

// file: hw/ppm_req_if.sv
/*
 * request carrier between the port sequencer and its write buffer.
 * assumes both ends on the same clock.
 */
interface ppm_req_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// file: hw/ppm_fifo.sv
/*
 * synchronous fifo with valid and ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
module ppm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic flush,
    ppm_req_if.dst in_side,
    ppm_req_if.src out_side
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } ppmf_state_t;

    ppmf_state_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full, empty, push, pop;

    // --------------------------------------------------------
    // flags and handshakes
    // --------------------------------------------------------
    assign empty = st.wr_ptr == st.rd_ptr;
    assign full = (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]) &&
                  (st.wr_ptr[AW] != st.rd_ptr[AW]);
    assign in_side.ready = !full;
    assign out_side.valid = !empty;
    assign out_side.data = mem[st.rd_ptr[AW-1:0]];
    assign push = in_side.valid && !full;
    assign pop = out_side.ready && !empty;

    // pointer update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        if (flush) begin
            next_st = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[st.wr_ptr[AW-1:0]] <= in_side.data;
        end
    end
endmodule

// file: hw/ppm_master.sv
/*
 * parallel port master: bus reads and writes on an external device,
 * started by data register reads and writes.
 * assumes configuration held still while the port is on.
 */
// Behaviour
// - both selects: a15/a14 pick device, 11 invalid
// - two selects give two 16K devices
// - upper select alone, a14 address: 32K
// - busy drops one cycle before operation end
// - base cycles read/write: 2/3,5/6,8/9,5/6
// - mode field 10 selects separate strobes
// - wide data bit one gives 16 bits
// - mux 01 partial; increment 01 steps up
// - irq mode 01 raises request per operation
// - strobes driven only when enabled
// - select function 10 uses both; polarity
// - begin/end wait 00 gives one cycle
// - middle wait stretches strobe, 01 one extra
// - address enable bits pick pins, others gpio
// - clearing on stops and resets the port
// - data read returns latched value, starts read
// - data write drives selects, address, data, strobe
// - busy set all operation cycles but last
// - requests while busy are ignored
// - address steps after operation completes
// - multiplexed: address on data, latch strobes
// - full mux forces selected bits to zero
module ppm_master #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic port_on,
    input wire logic [1:0] mode_field,
    input wire logic wide_data_bit,
    input wire logic [1:0] multiplex_field,
    input wire logic [1:0] increment_field,
    input wire logic [1:0] irq_mode_field,
    input wire logic read_strobe_enable,
    input wire logic write_strobe_enable,
    input wire logic [1:0] select_function_field,
    input wire logic read_polarity_bit,
    input wire logic write_polarity_bit,
    input wire logic select_hi_polarity_bit,
    input wire logic select_lo_polarity_bit,
    input wire logic latch_polarity_bit,
    input wire logic [1:0] begin_wait_field,
    input wire logic [3:0] middle_wait_field,
    input wire logic [1:0] end_wait_field,
    input wire logic [15:0] address_enable_register,
    input wire logic addr_write,
    input wire logic [15:0] addr_wdata,
    input wire logic data_write,
    input wire logic [15:0] data_wdata,
    input wire logic data_read,
    output logic [15:0] data_rdata,
    output logic [15:0] address_register,
    output logic busy,
    output logic data_write_ready,
    output logic port_irq,
    output logic [15:0] address_pins,
    output logic [15:0] address_pins_oe,
    output logic [15:0] data_pins_out,
    output logic [15:0] data_pins_oe,
    input wire logic [15:0] data_pins_in,
    output logic read_strobe,
    output logic read_strobe_oe,
    output logic write_strobe,
    output logic write_strobe_oe
);
    // ------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PPM_IDLE, PPM_ADDR, PPM_BEGIN, PPM_MID, PPM_END
    } ppm_phase_t;

    typedef struct packed {
        ppm_phase_t phase;
        logic is_read;
        logic [3:0] cnt;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic irq;
    } ppm_state_t;

    ppm_state_t st, next_st;
    ppm_req_if #(.WIDTH(16)) wq_in ();
    ppm_req_if #(.WIDTH(16)) wq_out ();
    logic start_rd, start_wr, act, flush;
    logic [3:0] addr_len, mid_len, begin_len, end_len;
    logic [1:0] cs_active;
    logic [15:0] bus_addr;

    // cycles of address phase for a multiplex mode
    function automatic logic [3:0] addr_cycles(input logic [1:0] mux);
        case (mux)
            ppm_pkg::MUX_PARTIAL: addr_cycles = ppm_pkg::ADDR_CYC_PARTIAL;
            ppm_pkg::MUX_FULL8: addr_cycles = ppm_pkg::ADDR_CYC_FULL8;
            ppm_pkg::MUX_FULL16: addr_cycles = ppm_pkg::ADDR_CYC_FULL16;
            default: addr_cycles = ppm_pkg::ADDR_CYC_DEMUX;
        endcase
    endfunction

    // ------------------------------------------------------------
    // write buffer between software writes and the bus
    // ------------------------------------------------------------
    assign flush = !port_on;
    assign wq_in.valid = data_write && port_on && !busy;
    assign wq_in.data = data_wdata;
    assign data_write_ready = wq_in.ready;
    assign wq_out.ready = (st.phase == PPM_IDLE) && !start_rd;

    ppm_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wq (
        .mclk(mclk),
        .rst(rst),
        .flush(flush),
        .in_side(wq_in),
        .out_side(wq_out)
    );

    // ------------------------------------------------------------
    // request decode and timing figures
    // ------------------------------------------------------------
    // reads start only when idle, so back-to-back ones are dropped
    assign start_rd = data_read && port_on && !busy &&
                      (st.phase == PPM_IDLE);
    assign start_wr = wq_out.valid && wq_out.ready;
    assign addr_len = addr_cycles(multiplex_field);
    // base data phase: two reads, three writes; waits add on top
    assign begin_len = 4'h1 + {2'h0, begin_wait_field};
    assign mid_len = middle_wait_field + 4'h1;
    assign end_len = {2'h0, end_wait_field} +
                     (st.is_read ? 4'h0 : 4'h1);
    assign act = st.phase != PPM_IDLE;

    // busy covers all but the last cycle of the operation
    assign busy = act && !(st.phase == PPM_END && st.cnt == 4'h0);

    // sequencer
    always_comb begin
        next_st = st;
        next_st.irq = 1'b0;
        case (st.phase)
            PPM_IDLE: begin
                if (start_rd || start_wr) begin
                    next_st.is_read = start_rd;
                    next_st.wdata = wq_out.data;
                    if (addr_len != 4'h0) begin
                        next_st.phase = PPM_ADDR;
                        next_st.cnt = addr_len - 4'h1;
                    end else begin
                        next_st.phase = PPM_BEGIN;
                        next_st.cnt = begin_len - 4'h1;
                    end
                end
            end
            PPM_ADDR: begin
                next_st.cnt = st.cnt - 4'h1;
                if (st.cnt == 4'h0) begin
                    next_st.phase = PPM_BEGIN;
                    next_st.cnt = begin_len - 4'h1;
                end
            end
            PPM_BEGIN: begin
                // data setup
                next_st.cnt = st.cnt - 4'h1;
                if (st.cnt == 4'h0) begin
                    next_st.phase = PPM_MID;
                    next_st.cnt = mid_len - 4'h1;
                end
            end
            PPM_MID: begin
                next_st.cnt = st.cnt - 4'h1;
                if (st.cnt == 4'h0) begin
                    if (st.is_read) begin
                        next_st.rdata = wide_data_bit ? data_pins_in :
                            {8'h00, data_pins_in[7:0]};
                    end
                    next_st.phase = PPM_END;
                    next_st.cnt = end_len;
                end
            end
            PPM_END: begin
                next_st.cnt = st.cnt - 4'h1;
                if (st.cnt == 4'h0) begin
                    next_st.phase = PPM_IDLE;
                    next_st.irq = irq_mode_field == ppm_pkg::IRQ_EVERY;
                    // step after the operation has completed
                    if (increment_field == ppm_pkg::INC_UP) begin
                        next_st.addr = st.addr + 16'h0001;
                    end else if (increment_field == ppm_pkg::INC_DOWN) begin
                        next_st.addr = st.addr - 16'h0001;
                    end
                    // chip-select bits do not take part in stepping
                    if (select_function_field == ppm_pkg::CSF_BOTH) begin
                        next_st.addr[15:14] = st.addr[15:14];
                    end else if (select_function_field ==
                                 ppm_pkg::CSF_HI_ONLY) begin
                        next_st.addr[15] = st.addr[15];
                    end
                end
            end
            default: begin
                next_st.phase = PPM_IDLE;
            end
        endcase
        if (addr_write && port_on && !busy) begin
            next_st.addr = addr_wdata;
        end
        if (!port_on) begin
            next_st.phase = PPM_IDLE;
            next_st.cnt = 4'h0;
            next_st.irq = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '{phase: PPM_IDLE, is_read: 1'b0, cnt: 4'h0,
                    addr: ppm_pkg::RST_ADDR, wdata: ppm_pkg::RST_DATA,
                    rdata: ppm_pkg::RST_DATA, irq: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // chip-select decode
    // ------------------------------------------------------------
    // select lines held over every phase of the operation
    always_comb begin
        cs_active = 2'b00;
        bus_addr = st.addr;
        if (select_function_field == ppm_pkg::CSF_BOTH) begin
            // 01 device one, 10 device two, 11 invalid: none
            cs_active[0] = st.addr[ppm_pkg::SEL_LO_BIT] &&
                           !st.addr[ppm_pkg::SEL_HI_BIT];
            cs_active[1] = st.addr[ppm_pkg::SEL_HI_BIT] &&
                           !st.addr[ppm_pkg::SEL_LO_BIT];
            bus_addr[15:14] = 2'b00;
        end else if (select_function_field == ppm_pkg::CSF_HI_ONLY) begin
            cs_active[1] = st.addr[ppm_pkg::SEL_HI_BIT];
            bus_addr[15] = 1'b0;
        end
        cs_active = act ? cs_active : 2'b00;
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // address, latch strobes, selects; address phase and write data phase drive data pins
    always_comb begin
        address_pins = st.addr;
        address_pins_oe = address_enable_register;
        data_pins_out = st.wdata;
        data_pins_oe = 16'h0000;
        if (multiplex_field != ppm_pkg::MUX_DEMUX) begin
            address_pins[ppm_pkg::ALL_PIN] = latch_polarity_bit ^
                !(st.phase == PPM_ADDR);
            address_pins_oe[ppm_pkg::ALL_PIN] = 1'b1;
            if (multiplex_field != ppm_pkg::MUX_PARTIAL) begin
                address_pins[ppm_pkg::ALH_PIN] = latch_polarity_bit ^
                    !(st.phase == PPM_ADDR);
                address_pins_oe[ppm_pkg::ALH_PIN] = 1'b1;
            end
        end
        if (st.phase == PPM_ADDR) begin
            data_pins_oe = (multiplex_field == ppm_pkg::MUX_FULL16) ?
                16'hFFFF : 16'h00FF;
            data_pins_out = (multiplex_field == ppm_pkg::MUX_FULL8 &&
                st.cnt < 4'h3) ? {8'h00, bus_addr[15:8]} : bus_addr;
        end else if (act && !st.is_read) begin
            data_pins_oe = wide_data_bit ? 16'hFFFF : 16'h00FF;
        end
        // selects replace the top address lines, forced on
        if (select_function_field == ppm_pkg::CSF_BOTH) begin
            address_pins[ppm_pkg::SEL_LO_BIT] =
                select_lo_polarity_bit ^ !cs_active[0];
            address_pins_oe[ppm_pkg::SEL_LO_BIT] = 1'b1;
        end
        if (select_function_field != ppm_pkg::CSF_A15_A14) begin
            address_pins[ppm_pkg::SEL_HI_BIT] =
                select_hi_polarity_bit ^ !cs_active[1];
            address_pins_oe[ppm_pkg::SEL_HI_BIT] = 1'b1;
        end
    end

    // strobes: only master mode two, only when enabled
    always_comb begin
        read_strobe = read_polarity_bit ^ !(st.is_read &&
            st.phase == PPM_MID);
        write_strobe = write_polarity_bit ^ !(!st.is_read &&
            st.phase == PPM_MID);
        read_strobe_oe = port_on && read_strobe_enable &&
            mode_field == ppm_pkg::MODE_MASTER2;
        write_strobe_oe = port_on && write_strobe_enable &&
            mode_field == ppm_pkg::MODE_MASTER2;
    end

    // latched read value, previous bus read
    assign data_rdata = st.rdata;
    assign address_register = st.addr;
    assign port_irq = st.irq;
endmodule

// file: tb/ppm_master_checker.sv
/*
 * concurrent checks on the port master's pins and flags.
 * assumes a bind to ppm_master: one clock, sync reset.
 */
module ppm_master_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic port_on,
    input wire logic [1:0] multiplex_field,
    input wire logic [1:0] irq_mode_field,
    input wire logic read_strobe_enable,
    input wire logic write_strobe_enable,
    input wire logic [1:0] select_function_field,
    input wire logic read_polarity_bit,
    input wire logic write_polarity_bit,
    input wire logic select_hi_polarity_bit,
    input wire logic select_lo_polarity_bit,
    input wire logic [15:0] address_enable_register,
    input wire logic [15:0] address_register,
    input wire logic busy,
    input wire logic port_irq,
    input wire logic [15:0] address_pins,
    input wire logic [15:0] address_pins_oe,
    input wire logic [15:0] data_pins_oe,
    input wire logic read_strobe,
    input wire logic read_strobe_oe,
    input wire logic write_strobe,
    input wire logic write_strobe_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic rd_on, wr_on, cs_ok;
    logic [15:0] ar;
    // active strobes, both-select mode
    assign rd_on = read_strobe_oe && read_strobe == read_polarity_bit;
    assign wr_on = write_strobe_oe && write_strobe == write_polarity_bit;
    assign cs_ok = select_function_field == ppm_pkg::CSF_BOTH;
    assign ar = address_register;
    // pin and flag checks
    rd_gate_a: assert property (
        !read_strobe_enable |-> !read_strobe_oe) else $error("rd driven");
    wr_gate_a: assert property (
        !write_strobe_enable |-> !write_strobe_oe) else $error("wr driven");
    strobe_busy_a: assert property (
        rd_on || wr_on |-> busy) else $error("strobe outside op");
    addr_hold_a: assert property (
        busy && port_on ##1 port_on |-> $stable(ar))
        else $error("address moved in op");
    cs_valid_a: assert property (
        cs_ok && !multiplex_field[1] && busy && $past(busy) && ar[15:14]
        != 2'h3 |-> address_pins[15:14] == (ar[15:14] ~^
        {select_hi_polarity_bit, select_lo_polarity_bit}))
        else $error("select level wrong");
    cs_bad_a: assert property (
        cs_ok && busy && ar[15:14] == 2'h3 |-> address_pins[15:14] ==
        ~{select_hi_polarity_bit, select_lo_polarity_bit})
        else $error("invalid select asserted");
    irq_pulse_a: assert property (
        irq_mode_field == ppm_pkg::IRQ_EVERY && port_on && $fell(busy)
        |=> port_irq) else $error("no irq pulse");
    data_drive_a: assert property (
        wr_on |-> data_pins_oe[7:0] == 8'hFF) else $error("data undriven");
    aen_pins_a: assert property (
        port_on && multiplex_field == ppm_pkg::MUX_DEMUX [*2] |->
        address_pins_oe[13:0] == address_enable_register[13:0])
        else $error("address pin enable wrong");
    // main scenarios reached
    cover property (wr_on && cs_ok);
    cover property (port_irq);
    cover property (rd_on [*3]);
endmodule

// file: tb/ppm_mem_model.sv
/*
 * behavioural external memory, 256 words of 16 bits.
 * assumes the low address byte on pins or latched.
 */
module ppm_mem_model (
    input wire logic mclk,
    input wire logic mux_en,
    input wire logic latch_pol,
    input wire logic rd_pol,
    input wire logic wr_pol,
    input wire logic [15:0] address_pins,
    input wire logic [15:0] data_pins_out,
    input wire logic read_strobe,
    input wire logic read_strobe_oe,
    input wire logic write_strobe,
    input wire logic write_strobe_oe,
    output logic [15:0] data_pins_in,
    output int wr_count,
    output logic [23:0] wr_last
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [256];
    logic [15:0] idle_v = 16'hA5A5;
    logic [7:0] alat, a;
    logic rd_on, wr_on, wr_was;
    initial wr_count = 0;
    // decode strobes; a released bus toggles
    assign rd_on = read_strobe_oe && read_strobe == rd_pol;
    assign wr_on = write_strobe_oe && write_strobe == wr_pol;
    assign a = mux_en ? alat : address_pins[7:0];
    assign data_pins_in = rd_on ? mem[a] : idle_v;
    // latch address, store, report writes
    always @(posedge mclk) begin
        idle_v <= ~idle_v;
        wr_was <= wr_on;
        if (mux_en && address_pins[0] == latch_pol)
            alat <= data_pins_out[7:0];
        if (wr_on)
            mem[a] <= data_pins_out;
        if (wr_was && !wr_on) begin
            wr_count <= wr_count + 1;
            wr_last <= {a, mem[a]};
        end
    end
endmodule

// file: tb/testbench.sv
/*
 * self-checking bench of the port master with a memory model.
 * assumes the package and design compiled first.
 */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst, port_on, wide_data_bit, read_strobe_enable;
    logic write_strobe_enable, read_polarity_bit, write_polarity_bit;
    logic select_hi_polarity_bit, select_lo_polarity_bit, busy;
    logic latch_polarity_bit, addr_write, data_write, data_read;
    logic [1:0] mode_field, multiplex_field, increment_field;
    logic [1:0] irq_mode_field, select_function_field;
    logic [1:0] begin_wait_field, end_wait_field;
    logic [3:0] middle_wait_field;
    logic [15:0] address_enable_register, addr_wdata, data_wdata;
    logic [15:0] data_rdata, address_register, address_pins, ea;
    logic [15:0] address_pins_oe, data_pins_out, data_pins_oe, data_pins_in;
    logic data_write_ready, port_irq, read_strobe, read_strobe_oe;
    logic write_strobe, write_strobe_oe;
    logic [23:0] wr_last, expq [$];
    logic [15:0] wd [4];
    logic [7:0] wt [5] = '{8'h00, 8'h04, 8'h0C, 8'h40, 8'h01};
    int dlt [4] = '{0, 3, 6, 3};
    int failures = 0, cmp_count = 0, seen = 0, wr_count, nb, ns, r0;
    bit track = 1'b0;
    ppm_master #(.FIFO_DEPTH(16)) u_ppm_master (
        .mclk, .rst, .port_on, .mode_field, .wide_data_bit,
        .multiplex_field, .increment_field, .irq_mode_field,
        .read_strobe_enable, .write_strobe_enable, .select_function_field,
        .read_polarity_bit, .write_polarity_bit, .select_hi_polarity_bit,
        .select_lo_polarity_bit, .latch_polarity_bit, .begin_wait_field,
        .middle_wait_field, .end_wait_field, .address_enable_register,
        .addr_write, .addr_wdata, .data_write, .data_wdata, .data_read,
        .data_rdata, .address_register, .busy, .data_write_ready,
        .port_irq, .address_pins, .address_pins_oe, .data_pins_out,
        .data_pins_oe, .data_pins_in, .read_strobe, .read_strobe_oe,
        .write_strobe, .write_strobe_oe);
    ppm_mem_model u_ppm_mem_model (.mclk, .mux_en(|multiplex_field),
        .latch_pol(latch_polarity_bit), .rd_pol(read_polarity_bit),
        .wr_pol(write_polarity_bit), .address_pins, .data_pins_out,
        .read_strobe, .read_strobe_oe, .write_strobe, .write_strobe_oe,
        .data_pins_in, .wr_count, .wr_last);
    // clock source
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // verdict and end of run
    task automatic stop_test();
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 200 && busy !== 1'b0; i++)
            tick();
        if (busy !== 1'b0) begin
            failures++;
            stop_test();
        end
    endtask
    // one request (0 read, 1 write, 2 address), then count cycles
    task automatic op(input int k, input logic [15:0] v, input int n);
        wait_idle();
        {nb, ns} = '0;
        {data_read, data_write, addr_write} = 3'h4 >> k;
        {data_wdata, addr_wdata} = {v, v};
        tick();
        {data_read, data_write, addr_write} = 3'h0;
        for (int i = 0; i < n; i++) begin
            nb += int'(busy === 1'b1);
            ns += int'(read_strobe_oe === 1'b1
                && read_strobe === read_polarity_bit);
            tick();
        end
    endtask
    // stop, configure, restart
    task automatic cfg(input logic [1:0] mx, input logic [7:0] w,
        input logic rse);
        wait_idle();
        port_on = 1'b0;
        tick();
        multiplex_field = mx;
        {begin_wait_field, middle_wait_field, end_wait_field} = w;
        {read_polarity_bit, write_polarity_bit, select_hi_polarity_bit,
            select_lo_polarity_bit, latch_polarity_bit} = 5'($urandom);
        wide_data_bit = mx != ppm_pkg::MUX_FULL8;
        read_strobe_enable = rse;
        tick();
        port_on = 1'b1;
        tick();
    endtask
    // each bus write takes the oldest note
    initial forever begin
        @(posedge mclk);
        #2;
        if (track && wr_count != seen)
            chk(wr_last, expq.size() > 0 ?
                expq.pop_front() : 32'hFFFF_FFFF);
        seen = wr_count;
    end
    // main sequence
    initial begin
        r0 = $urandom(99);
        {addr_write, data_write, data_read, port_on} = 4'h0;
        {addr_wdata, data_wdata, multiplex_field} = '0;
        rst = 1'b1;
        wide_data_bit = 1'b1;
        mode_field = ppm_pkg::MODE_MASTER2;
        increment_field = ppm_pkg::INC_UP;
        irq_mode_field = ppm_pkg::IRQ_EVERY;
        {read_strobe_enable, write_strobe_enable} = 2'h3;
        select_function_field = ppm_pkg::CSF_BOTH;
        address_enable_register = 16'hFFFF;
        repeat (2) tick();
        rst = 1'b0;
        chk(data_rdata, ppm_pkg::RST_DATA);
        chk(address_register, ppm_pkg::RST_ADDR);
        for (int m = 0; m < 2; m++) begin
            cfg(2'(m), 8'h00, 1'b1);
            track = 1'b1;
            ea = 16'h4010;
            op(2, ea, 1);
            for (int j = 0; j < 4; j++) begin
                wd[j] = 16'($urandom);
                expq.push_back({ea[7:0], wd[j]});
                op(1, wd[j], 1);
                ea++;
            end
            chk(busy, 1'b1);
            {data_write, data_read} = 2'h3;
            tick();
            {data_write, data_read} = 2'h0;
            wait_idle();
            tick();
            chk(address_register, ea);
            for (int k = 0; k < 2; k++) begin
                op(2, {2'(k + 2), 14'h3}, 1);
                expq.push_back({8'h03, wd[k]});
                op(1, wd[k], 1);
            end
            op(2, 16'h4010, 1);
            op(0, 16'h0, 1);
            for (int j = 0; j < 4; j++) begin
                wait_idle();
                tick();
                chk(data_rdata, wd[j]);
                op(0, 16'h0, 1);
            end
            wait_idle();
            repeat (3) tick();
            chk(expq.size(), 0);
            track = 1'b0;
        end
        for (int m = 0; m < 4; m++) begin
            cfg(2'(m), 8'h00, 1'b1);
            op(0, 16'h0, 40);
            r0 = (m == 0) ? nb : r0;
            chk(nb - r0, dlt[m]);
            op(1, 16'h0, 40);
            chk(nb - r0, dlt[m] + 1);
        end
        foreach (wt[k]) begin
            cfg(ppm_pkg::MUX_DEMUX, wt[k], 1'b1);
            op(0, 16'h0, 40);
            r0 = (k == 0) ? nb : r0;
            chk(nb - r0, wt[k][7:6] + wt[k][5:2] + wt[k][1:0]);
            chk(ns, 1 + wt[k][5:2]);
        end
        cfg(ppm_pkg::MUX_DEMUX, 8'h00, 1'b0);
        op(0, 16'h0, 40);
        chk(ns, 0);
        port_on = 1'b0;
        r0 = wr_count;
        op(1, 16'h5A5A, 20);
        chk(nb, 0);
        chk(wr_count - r0, 0);
        stop_test();
    end
endmodule
bind ppm_master ppm_master_checker u_ppm_master_checker (
    .mclk, .rst, .port_on, .multiplex_field, .irq_mode_field,
    .read_strobe_enable, .write_strobe_enable, .select_function_field,
    .read_polarity_bit, .write_polarity_bit, .select_hi_polarity_bit,
    .select_lo_polarity_bit, .address_enable_register, .address_register,
    .busy, .port_irq, .address_pins, .address_pins_oe, .data_pins_oe,
    .read_strobe, .read_strobe_oe, .write_strobe, .write_strobe_oe);
